// ==== rtl/fta_mapper.sv ====
// Transmit side of a fractional T1 aggregate built from four DTE channels.
// Assumes pins from outside arrive asynchronously and a strobe register port on i_clk.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module fta_mapper
  import fta_pkg::*;
#(
  parameter int HAS_STATION = 1,
  parameter int XTAL_DIV = FTA_XTAL_DIV,
  parameter int TCLK_LOSS_CYC = FTA_TCLK_LOSS_CYC
) (
  input wire logic i_clk, // System clock, 100 MHz.
  input wire logic i_rst_n, // Asynchronous reset, active low.
  input wire logic [7:0] i_addr, // Register byte address.
  input wire logic [31:0] i_wdata, // Register write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  output logic [31:0] o_rdata, // Read data, valid the cycle after i_rd.
  input wire logic i_rx_clk, // Clock recovered from network receive data.
  input wire logic i_stn_clk, // External station clock.
  input wire logic [1:0] i_line_attenuation_switch, // Rear switch position.
  input wire logic [3:0] i_ch_txd, // DTE transmit data per channel.
  input wire logic [3:0] i_terminal_tx_clock, // DTE transmit clock per channel.
  input wire logic [3:0] i_ch_rts, // DTE request to send per channel.
  output logic [3:0] o_ch_sclk, // Send timing to each DTE.
  output logic o_line_pos, // Positive line pulse.
  output logic o_line_neg, // Negative line pulse.
  output logic o_line_strobe, // One cycle per new line symbol.
  output logic o_attenuation_error_flag, // Illegal switch setting in DSX-1 mode.
  output logic [2:0] o_pulse_sel // Output pulse distance, zero in CSU mode.
);

  logic [15:0] pin_meta_r;
  logic [15:0] pin_sync_r;
  logic rx_s, stn_s;
  logic [1:0] sw_s;
  logic [3:0] txd_s, tclk_s, rts_s;
  logic rx_d_r, stn_d_r;
  logic [3:0] tclk_d_r;
  fta_agg_t agg_r;
  fta_ch_t ch_r [FTA_NCH];
  logic [3:0] rate_ok_r;
  logic refused_r;
  logic [3:0] tclk_act;
  logic [2:0] eff_tm, eff_tm_r;
  logic [6:0] div_r;
  logic [8:0] acc_r;
  logic stn_tick, tick;
  logic [2:0] bit_r;
  logic [4:0] slot_r;
  logic [4:0] frame_r;
  logic [7:0] cons_r [FTA_NCH];
  logic [3:0] hold_r;
  logic [3:0] take;
  logic [3:0] lvl_d_r;
  logic f_bit, map_bit, enf_bit;
  logic [5:0] crc_r, crc_tx_r, crc_nxt;
  logic [6:0] zc_r;
  logic [6:0] zlim;
  logic [7:0] dl_r;
  logic [15:0] tag_r;
  logic last_pol_r;
  logic sub_hit;

  // Every asynchronous pin passes two flops before use.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta_r <= 16'h0000;
      pin_sync_r <= 16'h0000;
    end else begin
      pin_meta_r <= {i_rx_clk, i_stn_clk, i_line_attenuation_switch, i_ch_txd,
                     i_terminal_tx_clock, i_ch_rts};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign rx_s = pin_sync_r[15];
  assign stn_s = pin_sync_r[14];
  assign sw_s = pin_sync_r[13:12];
  assign txd_s = pin_sync_r[11:8];
  assign tclk_s = pin_sync_r[7:4];
  assign rts_s = pin_sync_r[3:0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_d_r <= 1'b0;
      stn_d_r <= 1'b0;
      tclk_d_r <= 4'h0;
    end else begin
      rx_d_r <= rx_s;
      stn_d_r <= stn_s;
      tclk_d_r <= tclk_s;
    end
  end

  // Whether a write to channel k may take its rate and start slot.
  function automatic logic ch_legal(input int k, input fta_ch_t c);
    logic ok;
    logic [6:0] lo, hi, olo, ohi;
    ok = (fta_rate_bits(agg_r.rate_family_select, c.rate_idx) != 8'h00);
    ok = ok && (c.slot_packing_mode != 2'h3);
    lo = {2'b00, c.start_slot};
    hi = lo + {1'b0, fta_span(agg_r.rate_family_select, c)} - 7'h01;
    ok = ok && (lo >= 7'h01) && (hi <= 7'(FTA_SLOTS));
    for (int j = 0; j < FTA_NCH; j++) begin
      olo = {2'b00, ch_r[j].start_slot};
      ohi = olo + {1'b0, fta_span(agg_r.rate_family_select, ch_r[j])} - 7'h01;
      if (j != k && rate_ok_r[j] && lo <= ohi && olo <= hi) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : ch_legal

  // Aggregate configuration register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      agg_r <= FTA_AGG_RST;
    end else if (i_wr && i_addr == FTA_AGG_OFS) begin
      agg_r <= fta_agg_t'(i_wdata[$bits(fta_agg_t)-1:0]);
      if (i_wdata[2:0] > FTA_TM_STN) begin
        agg_r.timing <= FTA_TM_INT;
      end else if (HAS_STATION != 0 && i_wdata[2:0] == FTA_TM_CH3) begin
        agg_r.timing <= FTA_TM_INT;
      end else if (HAS_STATION == 0 && i_wdata[2:0] == FTA_TM_STN) begin
        agg_r.timing <= FTA_TM_INT;
      end
      if (i_wdata[4:3] == 2'h3) begin
        agg_r.framing <= FTA_FR_D4;
      end
      if (i_wdata[9:7] > FTA_DIST_MAX) begin
        agg_r.pulse_dist <= FTA_DIST_MAX;
      end
      if (i_wdata[20:13] == 8'h00) begin
        agg_r.stn_rate <= 8'h01;
      end else if ({1'b0, i_wdata[20:13]} > FTA_STN_MAX) begin
        agg_r.stn_rate <= FTA_STN_MAX[7:0];
      end
    end
  end

  // Channel configuration and rate validity.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < FTA_NCH; k++) begin
        ch_r[k] <= FTA_CH_RST;
      end
      rate_ok_r <= 4'h0;
      refused_r <= 1'b0;
    end else if (i_wr && i_addr == FTA_AGG_OFS) begin
      if (i_wdata[10] != agg_r.rate_family_select) begin
        rate_ok_r <= 4'h0;
      end
    end else if (i_wr) begin
      for (int k = 0; k < FTA_NCH; k++) begin
        if (i_addr == FTA_CH_OFS + 8'(k) * FTA_CH_STRIDE) begin
          ch_r[k] <= fta_ch_t'(i_wdata[15:0]);
          if (rate_ok_r[k] && i_wdata[1:0] != ch_r[k].slot_packing_mode) begin
            rate_ok_r[k] <= 1'b0;
            refused_r <= 1'b0;
          end else begin
            rate_ok_r[k] <= ch_legal(k, fta_ch_t'(i_wdata[15:0]));
            refused_r <= !ch_legal(k, fta_ch_t'(i_wdata[15:0]));
          end
        end
      end
    end
  end

  // DTE clock presence, capture clock and held data per channel.
  genvar g;
  generate
    for (g = 0; g < FTA_NCH; g++) begin : g_ch
      logic [14:0] idle_r;
      logic lvl;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          idle_r <= 15'h7FFF;
        end else if (tclk_s[g] && !tclk_d_r[g]) begin
          idle_r <= 15'h0000;
        end else if (idle_r != 15'h7FFF) begin
          idle_r <= idle_r + 15'h0001;
        end
      end
      assign tclk_act[g] = (int'(idle_r) < TCLK_LOSS_CYC);
      // First loop takes the DTE clock while it runs, else the send clock.
      assign lvl = (ch_r[g].loop1 && tclk_act[g]) ? (tclk_s[g] ^ ch_r[g].clk_inv)
                                                   : o_ch_sclk[g];
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          lvl_d_r[g] <= 1'b0;
          hold_r[g] <= 1'b1;
          o_ch_sclk[g] <= 1'b0;
        end else begin
          lvl_d_r[g] <= lvl;
          if (lvl && !lvl_d_r[g]) begin
            hold_r[g] <= txd_s[g];
          end
          o_ch_sclk[g] <= take[g] ^ ch_r[g].clk_inv;
        end
      end
    end
  endgenerate

  // Timing source actually in use.
  always_comb begin
    eff_tm = agg_r.timing;
    if (agg_r.timing == FTA_TM_CH1) begin
      if (!(rate_ok_r[0] && ch_r[0].loop1 && tclk_act[0])) begin
        eff_tm = FTA_TM_INT;
      end
    end else if (agg_r.timing == FTA_TM_CH3) begin
      if (!(rate_ok_r[2] && ch_r[2].loop1 && tclk_act[2])) begin
        eff_tm = FTA_TM_INT;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eff_tm_r <= FTA_TM_INT;
    end else begin
      eff_tm_r <= eff_tm;
    end
  end

  // Crystal divider and station-clock rate converter.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= 7'h00;
      acc_r <= 9'h000;
    end else begin
      div_r <= (int'(div_r) >= XTAL_DIV - 1) ? 7'h00 : div_r + 7'h01;
      if (eff_tm_r != FTA_TM_STN) begin
        acc_r <= 9'h000;
      end else begin
        acc_r <= acc_r + ((stn_s && !stn_d_r) ? FTA_STN_MAX : 9'h000) -
                 (stn_tick ? {1'b0, agg_r.stn_rate} : 9'h000);
      end
    end
  end

  // Station ticks sit on the crystal grid so line strobes and send clocks stay single pulses.
  assign stn_tick = (acc_r >= {1'b0, agg_r.stn_rate}) && (div_r == 7'h00);

  always_comb begin
    case (eff_tm_r)
      FTA_TM_LOOP: tick = rx_s && !rx_d_r;
      FTA_TM_CH1: tick = tclk_s[0] && !tclk_d_r[0];
      FTA_TM_CH3: tick = tclk_s[2] && !tclk_d_r[2];
      FTA_TM_STN: tick = stn_tick;
      default: tick = (div_r == 7'h00);
    endcase
  end

  // Frame position: slot 0 is the framing bit, slots 1 to 24 carry eight bits each.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_r <= 3'h0;
      slot_r <= 5'h00;
      frame_r <= 5'h00;
    end else if (tick) begin
      if (slot_r == 5'h00) begin
        slot_r <= 5'h01;
        bit_r <= 3'h0;
      end else if (bit_r == 3'h7) begin
        bit_r <= 3'h0;
        if (slot_r == 5'(FTA_SLOTS)) begin
          slot_r <= 5'h00;
          frame_r <= (frame_r == 5'(FTA_ESF_FRAMES - 1)) ? 5'h00 : frame_r + 5'h01;
        end else begin
          slot_r <= slot_r + 5'h01;
        end
      end else begin
        bit_r <= bit_r + 3'h1;
      end
    end
  end

  // Framing bit for the current frame.
  always_comb begin
    logic [4:0] f12;
    f12 = (frame_r >= 5'd12) ? frame_r - 5'd12 : frame_r;
    f_bit = 1'b1;
    if (agg_r.framing == FTA_FR_D4) begin
      f_bit = FTA_D4_PATTERN[4'(5'd11 - f12)];
    end else if (frame_r[1:0] == 2'h3) begin
      f_bit = FTA_FPS_PATTERN[3'(3'd5 - frame_r[4:2])];
    end else if (frame_r[1:0] == 2'h1) begin
      f_bit = crc_tx_r[3'(3'd5 - frame_r[4:2])];
    end else if (agg_r.framing == FTA_FR_ESF_A) begin
      f_bit = FTA_DL_FLAG[3'(3'd7 - frame_r[3:1])];
    end
  end

  // Slot mapper: picks the owning channel and the bit it places here.
  always_comb begin
    logic [5:0] rel;
    logic [5:0] span;
    logic [3:0] per;
    logic data_slot;
    rel = 6'h00;
    span = 6'h00;
    per = 4'h0;
    data_slot = 1'b0;
    map_bit = 1'b1;
    take = 4'h0;
    for (int k = 0; k < FTA_NCH; k++) begin
      rel = {1'b0, slot_r} - {1'b0, ch_r[k].start_slot};
      span = fta_span(agg_r.rate_family_select, ch_r[k]);
      per = (ch_r[k].slot_packing_mode == FTA_PK_STUFF) ? 4'h7 : 4'h8;
      data_slot = rate_ok_r[k] && slot_r != 5'h00 && slot_r >= ch_r[k].start_slot &&
                  rel < span && (ch_r[k].slot_packing_mode != FTA_PK_ALT || !rel[0]);
      if (data_slot && {1'b0, bit_r} < per &&
          cons_r[k] < fta_need(agg_r.rate_family_select, ch_r[k])) begin
        if (ch_r[k].rts_carry && cons_r[k] == 8'h00) begin
          map_bit = rts_s[k];
        end else if (ch_r[k].rts_carry && !rts_s[k]) begin
          map_bit = 1'b1;
        end else begin
          map_bit = hold_r[k] ^ ch_r[k].data_inv;
          take[k] = tick;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < FTA_NCH; k++) begin
        cons_r[k] <= 8'h00;
      end
    end else if (tick) begin
      for (int k = 0; k < FTA_NCH; k++) begin
        if (slot_r == 5'h00) begin
          cons_r[k] <= 8'h00;
        end else if (take[k]) begin
          cons_r[k] <= cons_r[k] + 8'h01;
        end
      end
      for (int k = 0; k < FTA_NCH; k++) begin
        if (slot_r != 5'h00 && ch_r[k].rts_carry && !take[k] && rate_ok_r[k] &&
            slot_r >= ch_r[k].start_slot &&
            ({1'b0, slot_r} - {1'b0, ch_r[k].start_slot}) <
            fta_span(agg_r.rate_family_select, ch_r[k]) &&
            (ch_r[k].slot_packing_mode != FTA_PK_ALT ||
             !(slot_r[0] ^ ch_r[k].start_slot[0])) &&
            ({1'b0, bit_r} < ((ch_r[k].slot_packing_mode == FTA_PK_STUFF) ? 4'h7 : 4'h8)) &&
            cons_r[k] < fta_need(agg_r.rate_family_select, ch_r[k])) begin
          cons_r[k] <= cons_r[k] + 8'h01;
        end
      end
    end
  end

  // CRC-6 over each superframe, framing bits taken as ones, sent in the next one.
  assign crc_nxt = {crc_r[4:0], 1'b0} ^
                   ((crc_r[5] ^ (slot_r == 5'h00 ? 1'b1 : map_bit)) ? FTA_CRC_POLY : 6'h00);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      crc_r <= 6'h00;
      crc_tx_r <= 6'h00;
    end else if (tick) begin
      if (frame_r == 5'(FTA_ESF_FRAMES - 1) && slot_r == 5'(FTA_SLOTS) && bit_r == 3'h7) begin
        crc_tx_r <= crc_nxt;
        crc_r <= 6'h00;
      end else begin
        crc_r <= crc_nxt;
      end
    end
  end

  // Zero-density enforcer.
  always_comb begin
    case (agg_r.density)
      FTA_DN_8: zlim = 7'd7;
      FTA_DN_16: zlim = 7'd15;
      FTA_DN_64: zlim = 7'd63;
      default: zlim = 7'h7F;
    endcase
    enf_bit = (slot_r == 5'h00) ? f_bit : map_bit;
    if (agg_r.density != FTA_DN_NONE && !enf_bit && zc_r >= zlim) begin
      enf_bit = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zc_r <= 7'h00;
    end else if (tick) begin
      if (enf_bit) begin
        zc_r <= 7'h00;
      end else if (zc_r != 7'h7F) begin
        zc_r <= zc_r + 7'h01;
      end
    end
  end

  // Eight-bit delay line; B8ZS tags a run of eight zeros as 000BVBVB.
  assign sub_hit = agg_r.b8zs && {dl_r[6:0], enf_bit} == 8'h00 && tag_r[13:0] == 14'h0000;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dl_r <= 8'h00;
      tag_r <= 16'h0000;
      last_pol_r <= 1'b0;
      o_line_pos <= 1'b0;
      o_line_neg <= 1'b0;
      o_line_strobe <= 1'b0;
    end else begin
      o_line_strobe <= tick;
      if (tick) begin
        dl_r <= {dl_r[6:0], enf_bit};
        if (sub_hit) begin
          tag_r <= 16'h0266;
        end else begin
          tag_r <= {tag_r[13:0], 2'b00};
        end
        if (tag_r[15:14] == 2'h1) begin
          o_line_pos <= last_pol_r;
          o_line_neg <= !last_pol_r;
        end else if (tag_r[15:14] == 2'h2 || dl_r[7]) begin
          o_line_pos <= !last_pol_r;
          o_line_neg <= last_pol_r;
          last_pol_r <= !last_pol_r;
        end else begin
          o_line_pos <= 1'b0;
          o_line_neg <= 1'b0;
        end
      end
    end
  end

  // Line interface type outputs.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pulse_sel <= 3'h0;
      o_attenuation_error_flag <= 1'b0;
    end else begin
      o_pulse_sel <= agg_r.dsx1 ? agg_r.pulse_dist : 3'h0;
      o_attenuation_error_flag <= agg_r.dsx1 && sw_s != FTA_SW_0DB;
    end
  end

  // Register read port.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (!i_rd) begin
      o_rdata <= 32'h00000000;
    end else if (i_addr == FTA_AGG_OFS) begin
      o_rdata <= {11'h000, agg_r};
    end else if (i_addr == FTA_STATUS_OFS) begin
      o_rdata <= {17'h00000, refused_r, tclk_act, rate_ok_r, sw_s,
                  o_attenuation_error_flag, eff_tm_r};
    end else if (i_addr >= FTA_CH_OFS && i_addr < FTA_STATUS_OFS && i_addr[1:0] == 2'h0) begin
      o_rdata <= {16'h0000, ch_r[2'(i_addr[4:2] - 3'h1)]};
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule : fta_mapper

// ==== rtl/fta_pkg.sv ====
// Constants, field layouts and lookup functions for the T1 aggregate channel mapper.
// Assumes a 100 MHz system clock and a plain strobe-based register port.
// Notes on behaviour
// - Aggregate timed from crystal, receive, channel or station
// - Station rate is N times 8 kb/s
// - Station variant offers no channel 3 timing
// - Channel timing needs that channel in first loop
// - Framing is D4 or two extended superframes
// - Line code is AMI or B8ZS
// - Pulse distance applies in DSX-1 only
// - DSX-1 with attenuation switch off 0 dB flags error
// - Channel rates come from selected family table
// - Family change invalidates all channel rates
// - Family does not affect slot packing
// - Density enforcer forces Nth zero to one
// - Full byte packing puts eight bits per slot
// - Every other slot packing fills gaps with ones
// - Seventh bit stuffing forces eighth bit one
// - Packing change invalidates that channel's rate
// - Slot and rate allocation is exclusive, slots 1-24
// - First loop uses DTE clock, second uses send clock
// - Missing DTE clock falls back to second loop
// - Clock inversion inverts the selected channel clock
// - Data inversion inverts channel data on network
// - Request ignore treats RTS as always asserted
// - Request carry sends RTS state with data
// - Channel timing without valid rate reverts to crystal
package fta_pkg;

  localparam int FTA_NCH = 4;
  localparam int FTA_SLOTS = 24;
  localparam int FTA_ESF_FRAMES = 24;

  localparam logic [7:0] FTA_AGG_OFS = 8'h00;
  localparam logic [7:0] FTA_CH_OFS = 8'h04;
  localparam logic [7:0] FTA_CH_STRIDE = 8'h04;
  localparam logic [7:0] FTA_STATUS_OFS = 8'h14;

  localparam int FTA_CLK_KHZ = 100000;
  localparam int FTA_T1_KBPS = 1544;
  localparam int FTA_XTAL_DIV = FTA_CLK_KHZ / FTA_T1_KBPS;
  localparam int FTA_STN_UNIT_KBPS = 8;
  localparam logic [8:0] FTA_STN_MAX = 9'(FTA_T1_KBPS / FTA_STN_UNIT_KBPS);
  localparam int FTA_TCLK_LOSS_US = 250;
  localparam int FTA_TCLK_LOSS_CYC = FTA_TCLK_LOSS_US * FTA_CLK_KHZ / 1000;

  localparam logic [11:0] FTA_D4_PATTERN = 12'h8DC;
  localparam logic [5:0] FTA_FPS_PATTERN = 6'h0B;
  localparam logic [7:0] FTA_DL_FLAG = 8'h7E;
  localparam logic [5:0] FTA_CRC_POLY = 6'h03;

  typedef enum logic [2:0] {
    FTA_TM_INT = 3'h0, FTA_TM_LOOP = 3'h1, FTA_TM_CH1 = 3'h2, FTA_TM_CH3 = 3'h3,
    FTA_TM_STN = 3'h4
  } fta_timing_t;
  typedef enum logic [1:0] {
    FTA_FR_D4 = 2'h0, FTA_FR_ESF_A = 2'h1, FTA_FR_ESF_B = 2'h2
  } fta_framing_t;
  typedef enum logic [1:0] {
    FTA_DN_NONE = 2'h0, FTA_DN_8 = 2'h1, FTA_DN_16 = 2'h2, FTA_DN_64 = 2'h3
  } fta_density_t;
  typedef enum logic [1:0] {
    FTA_PK_FULL = 2'h0, FTA_PK_ALT = 2'h1, FTA_PK_STUFF = 2'h2
  } fta_packing_t;
  typedef enum logic [1:0] {
    FTA_SW_0DB = 2'h0, FTA_SW_7DB5 = 2'h1, FTA_SW_15DB = 2'h2
  } fta_switch_t;

  // Aggregate configuration word, MSB first as it sits at FTA_AGG_OFS.
  typedef struct packed {
    logic [7:0] stn_rate;
    logic [1:0] density;
    logic rate_family_select;
    logic [2:0] pulse_dist;
    logic dsx1;
    logic b8zs;
    logic [1:0] framing;
    logic [2:0] timing;
  } fta_agg_t;

  // Per-channel configuration word.
  typedef struct packed {
    logic rts_carry;
    logic data_inv;
    logic clk_inv;
    logic loop1;
    logic [4:0] start_slot;
    logic [4:0] rate_idx;
    logic [1:0] slot_packing_mode;
  } fta_ch_t;

  localparam fta_agg_t FTA_AGG_RST = '{stn_rate: 8'hC1, density: FTA_DN_16,
    rate_family_select: 1'b0, pulse_dist: 3'h0, dsx1: 1'b0, b8zs: 1'b0,
    framing: FTA_FR_D4, timing: FTA_TM_INT};
  localparam fta_ch_t FTA_CH_RST = '0;
  localparam logic [2:0] FTA_DIST_MAX = 3'h4;

  // Data bits per frame (rate / 8 kb/s); zero marks an index outside the family.
  function automatic logic [7:0] fta_rate_bits(input logic fam56, input logic [4:0] idx);
    logic [7:0] t64 [18];
    logic [7:0] t56 [22];
    t64 = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28,
            8'h30, 8'h40, 8'h50, 8'h60, 8'h78, 8'hA0, 8'hC0};
    t56 = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0E, 8'h15, 8'h18,
            8'h1C, 8'h23, 8'h28, 8'h2A, 8'h38, 8'h46, 8'h54, 8'h69, 8'h78, 8'h8C, 8'hA8};
    if (fam56) begin
      return (idx < 5'd22) ? t56[idx] : 8'h00;
    end
    return (idx < 5'd18) ? t64[idx] : 8'h00;
  endfunction : fta_rate_bits

  // Payload positions per frame: data bits plus one status bit in request-carry mode.
  function automatic logic [7:0] fta_need(input logic fam56, input fta_ch_t c);
    return fta_rate_bits(fam56, c.rate_idx) + {7'h00, c.rts_carry};
  endfunction : fta_need

  // Number of consecutive slots a channel occupies.
  function automatic logic [5:0] fta_span(input logic fam56, input fta_ch_t c);
    logic [5:0] n;
    int per;
    n = 6'h00;
    per = (c.slot_packing_mode == FTA_PK_STUFF) ? 7 : 8;
    for (int i = 30; i >= 1; i--) begin
      if (i * per >= int'(fta_need(fam56, c))) begin
        n = 6'(i);
      end
    end
    if (c.slot_packing_mode == FTA_PK_ALT) begin
      n = 6'(2 * int'(n) - 1);
    end
    return n;
  endfunction : fta_span

endpackage : fta_pkg

// ==== tb/fta_dte_model.sv ====
// Behavioural DTE and receive clock source on the mapper's far side.
// Assumes the bench starts and stops the terminal clocks.
`timescale 1ns/1ps
module fta_dte_model (
  input wire logic i_run, // Clocks on.
  input wire logic [3:0] i_sclk, // Send timing.
  output logic [3:0] o_tclk, // Terminal clocks.
  output logic [3:0] o_txd, // Data.
  output logic o_rx_clk // Receive clock.
);
  logic [7:0] pat_r;
  initial begin
    o_tclk = 4'h0;
    o_rx_clk = 1'b0;
    pat_r = 8'hA5;
    #3;
    forever begin
      #40;
      o_rx_clk = ~o_rx_clk;
      o_tclk = i_run ? ~o_tclk : 4'h0;
    end
  end
  // Data moves on falling edges so a rising-edge capture sees it settled.
  always @(negedge o_tclk[0] or negedge i_sclk[0]) begin
    pat_r <= {pat_r[6:0], pat_r[7]};
  end
  assign o_txd = i_run ? {4{pat_r[7]}} : 4'hF;
endmodule : fta_dte_model

// ==== tb/fta_mapper_sva.sv ====
// Port checks for the mapper, bound to every instance of it.
// Assumes the strobe marks each new line symbol and reads answer one cycle later.
`timescale 1ns/1ps
module fta_mapper_sva
  import fta_pkg::*;
(
  input wire logic i_clk, // Clock.
  input wire logic i_rst_n, // Reset.
  input wire logic i_rd, // Read.
  input wire logic [31:0] o_rdata, // Read data.
  input wire logic [1:0] i_line_attenuation_switch, // Switch.
  input wire logic o_line_pos, // Mark high.
  input wire logic o_line_neg, // Mark low.
  input wire logic o_line_strobe, // New symbol.
  input wire logic o_attenuation_error_flag, // Error.
  input wire logic [2:0] o_pulse_sel // Distance.
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [6:0] zrun_r;
  // Length of the current run of zero symbols on the line.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zrun_r <= 7'h00;
    end else if (o_line_strobe) begin
      zrun_r <= (o_line_pos | o_line_neg) ? 7'h00 : zrun_r + 7'h01;
    end
  end
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside answer cycle");
  strobe_pulse_a: assert property (o_line_strobe |=> !o_line_strobe)
    else $error("symbol strobe longer than one cycle");
  pulse_range_a: assert property (o_pulse_sel <= FTA_DIST_MAX)
    else $error("pulse distance out of range");
  bipolar_excl_a: assert property (!(o_line_pos && o_line_neg))
    else $error("both line polarities at once");
  symbol_hold_a: assert property (
    !o_line_strobe |-> $stable({o_line_pos, o_line_neg}))
    else $error("line symbol changed without strobe");
  zero_run_a: assert property (zrun_r <= 7'h3F)
    else $error("zero run longer than enforcer allows");
  atten_ok_a: assert property (
    (i_line_attenuation_switch == 2'h0) [*4] |-> !o_attenuation_error_flag)
    else $error("switch error flagged at 0 dB");
  atten_bad_a: assert property (
    (o_pulse_sel != 3'h0 && i_line_attenuation_switch != 2'h0) [*4] |-> o_attenuation_error_flag)
    else $error("switch error missing in DSX-1 mode");
endmodule : fta_mapper_sva
bind fta_mapper fta_mapper_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_line_attenuation_switch(i_line_attenuation_switch),
  .o_line_pos(o_line_pos), .o_line_neg(o_line_neg), .o_line_strobe(o_line_strobe),
  .o_attenuation_error_flag(o_attenuation_error_flag), .o_pulse_sel(o_pulse_sel));

// ==== tb/test_t1_aggregate_channel_mapper.sv ====
// Self-checking bench for the T1 aggregate channel mapper.
// Assumes the DTE model and the bound checker.
`timescale 1ns/1ps
module test_t1_aggregate_channel_mapper;
  import fta_pkg::*;
  logic i_clk, i_rst_n, i_wr, i_rd, run, rx_clk, pos, neg, strobe, flag;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, st;
  logic [1:0] sw;
  logic [2:0] psel;
  logic [3:0] rts, tclk, txd, sclk;
  int mismatches, total_checks;
  fta_agg_t agg;
  fta_ch_t ch;
  fta_mapper #(.TCLK_LOSS_CYC(200)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_clk(rx_clk),
    .i_stn_clk(1'b0), .i_line_attenuation_switch(sw), .i_ch_txd(txd),
    .i_terminal_tx_clock(tclk), .i_ch_rts(rts), .o_ch_sclk(sclk), .o_line_pos(pos),
    .o_line_neg(neg), .o_line_strobe(strobe), .o_attenuation_error_flag(flag),
    .o_pulse_sel(psel));
  fta_dte_model u_dte (.i_run(run), .i_sclk(sclk), .o_tclk(tclk), .o_txd(txd), .o_rx_clk(rx_clk));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    repeat (3) @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 st = o_rdata;
  endtask : rd
  task automatic t_basic();
    fta_timing_t sel [4] = '{FTA_TM_LOOP, FTA_TM_CH3, FTA_TM_STN, FTA_TM_CH1};
    fta_timing_t exp [4] = '{FTA_TM_LOOP, FTA_TM_INT, FTA_TM_STN, FTA_TM_INT};
    rd(FTA_AGG_OFS);
    check("agg reset", st, 32'(FTA_AGG_RST));
    rd(8'h20);
    check("unmapped", st, 32'h0);
    for (int k = 0; k < 4; k++) begin
      agg.timing = sel[k];
      wr(FTA_AGG_OFS, 32'(agg));
      rd(FTA_STATUS_OFS);
      check("timing", 32'(st[2:0]), 32'(exp[k]));
    end
    agg.timing = FTA_TM_INT;
    agg.dsx1 = 1'b1;
    agg.pulse_dist = 3'h3;
    sw <= 2'h1;
    wr(FTA_AGG_OFS, 32'(agg));
    rd(FTA_STATUS_OFS);
    check("flag dsx", {st[5:3], flag, 25'h0, psel}, {3'h3, 1'b1, 25'h0, 3'h3});
    agg.dsx1 = 1'b0;
    sw <= 2'h2;
    wr(FTA_AGG_OFS, 32'(agg));
    rd(FTA_STATUS_OFS);
    check("flag csu", {flag, psel}, 32'h0);
    $display("basic test done");
  endtask : t_basic
  task automatic t_chan();
    ch = FTA_CH_RST;
    ch.start_slot = 5'd1;
    ch.loop1 = 1'b1;
    wr(FTA_CH_OFS, 32'(ch));
    wr(FTA_CH_OFS + FTA_CH_STRIDE, 32'(ch));
    run <= 1'b1;
    agg.timing = FTA_TM_CH1;
    wr(FTA_AGG_OFS, 32'(agg));
    repeat (30) @(posedge i_clk);
    rd(FTA_STATUS_OFS);
    check("claim", {st[14], st[10], st[7:6], st[2:0]}, {2'h3, 2'h1, FTA_TM_CH1});
    run <= 1'b0;
    repeat (300) @(posedge i_clk);
    rd(FTA_STATUS_OFS);
    check("clock lost", {st[10], st[2:0]}, {1'b0, FTA_TM_INT});
    ch.slot_packing_mode = FTA_PK_STUFF;
    wr(FTA_CH_OFS, 32'(ch));
    rd(FTA_STATUS_OFS);
    check("packing", st[6], 1'b0);
    wr(FTA_CH_OFS, 32'(ch));
    agg.rate_family_select = 1'b1;
    wr(FTA_AGG_OFS, 32'(agg));
    rd(FTA_STATUS_OFS);
    check("family", st[6], 1'b0);
    $display("channel test done");
  endtask : t_chan
  task automatic t_density();
    int run0 = 0, worst = 0, bad = 0;
    logic last = 1'bx;
    agg = FTA_AGG_RST;
    agg.density = FTA_DN_8;
    wr(FTA_AGG_OFS, 32'(agg));
    ch = FTA_CH_RST;
    ch.start_slot = 5'd1;
    ch.rate_idx = 5'd17;
    ch.data_inv = 1'b1;
    wr(FTA_CH_OFS, 32'(ch));
    wr(FTA_CH_OFS, 32'(ch));
    rts <= 4'h0;
    rd(FTA_STATUS_OFS);
    check("full rate", st[6], 1'b1);
    repeat (26000) begin
      @(negedge i_clk);
      if (strobe && (pos || neg)) begin
        bad += (pos === last);
        last = pos;
        run0 = 0;
      end else if (strobe) begin
        run0++;
        worst = (run0 > worst) ? run0 : worst;
      end
    end
    check("zero run", 32'(worst), 32'd7);
    check("polarity", 32'(bad), 32'd0);
    $display("density test done");
  endtask : t_density
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    {i_rst_n, i_wr, i_rd, run, i_addr, i_wdata, sw} = '0;
    rts = 4'hF;
    agg = FTA_AGG_RST;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_basic();
    t_chan();
    t_density();
    complete_run();
  end
  initial begin
    #400000;
    mismatches++;
    complete_run();
  end
endmodule : test_t1_aggregate_channel_mapper
